// File: common/remote_trigger_command_seq_pkg.sv
// Package of constants and carrier types for the measurement trigger sequencer.
package remote_trigger_command_seq_pkg;

	localparam int unsigned clk_mhz = 100;
	localparam int unsigned done_pulse_ns = 4000;
	localparam int unsigned done_pulse_cycles = (done_pulse_ns * clk_mhz) / 1000;
	localparam int unsigned gate_latency_us = 1000;
	localparam int unsigned gate_latency_cycles = gate_latency_us * clk_mhz;
	localparam int unsigned debounce_us = 10000;
	localparam int unsigned debounce_cycles_dflt = debounce_us * clk_mhz;
	localparam int unsigned count_max_std = 1000;
	localparam int unsigned count_max_exp = 8000;
	localparam int unsigned integration_time_setting_min = 1;
	localparam int unsigned integration_time_setting_max = 99999;
	localparam logic [2:0] digits_min = 3'h4;
	localparam logic [2:0] digits_max = 3'h7;
	localparam logic [2:0] burst_digits = 3'h4;
	localparam logic [3:0] kohm_range_lo = 4'h1;
	localparam logic [3:0] kohm_range_hi = 4'h5;

	typedef enum logic [2:0] {
		acq_sample,
		acq_capture,
		acq_gated,
		acq_burst
	} acq_mode_t;

	typedef enum logic [1:0] {
		func_vdc,
		func_idc,
		func_ohm,
		func_other
	} meas_func_t;

	typedef enum logic [2:0] {
		src_none,
		src_key,
		src_ext,
		src_timer,
		src_remote
	} remote_trigger_command_src_t;

	typedef struct packed {
		logic [2:0] digits;
		logic [16:0] integration_time_setting;
		logic integration_time_setting_on;
		logic track;
		logic filter;
		logic quotient;
		logic scan;
		logic comp_ohm;
		logic autorange;
		logic normal_output;
		logic [1:0] ext_edge_neg_debounce;
		acq_mode_t mode;
		logic [12:0] count;
		logic [12:0] overrun;
		logic expanded;
		logic integral_on;
	} settings_t;

	typedef struct packed {
		logic start;
		acq_mode_t mode;
		remote_trigger_command_src_t src;
		logic error;
	} start_event_t;

endpackage : remote_trigger_command_seq_pkg

// File: hdl/measurement_trigger_sequencer.sv
// Trigger sources, acquisition sequencing and done pulse for the measurement engine.
// Contract
// - Digits 4 to 7 and integration time 0000.1 to 9999.9 s are accepted.
// - Too many digits for the integration time display as supported; stored value kept.
// - Fewer digits than supported display only the configured digits.
// - Continuous run retriggers after delay plus measurement time.
// - Key, external input, timer or remote command each start acquisition.
// - Trigger indicator lights on accepted trigger until acquisition completes.
// - Sampled mode runs a user count of 1..1000, or 1..8000 expanded.
// - Gated measurement starts within 1 ms of a trigger, ends at next.
// - Gated needs no compensated ohms, quotient off, scan off, fixed range.
// - Capture measures until threshold, then takes overrun count and stops.
// - Selecting capture forces scanning off; quotient may stay.
// - Trigger indicator stays lit through capture wait and overrun.
// - Integral option multiplies value by gate time or integration time.
// - Burst forces 4 digits, filter, quotient, scan, track off, normal output.
// - Burst allowed only dc volts, dc current, ohm ranges fixed; else error.
// - In burst, any non-trigger command switches mode to sampled.
// - External edge polarity and debounce are selectable; edge acts as key.
// - Done output idles high, pulses low about 4 us per measurement.
// - Capture pulses only on first threshold result, high during overrun.
// - Bound-check violations with flag enabled each pulse the done output.
// - A trigger during acquisition aborts it and starts a new one, except with the gate open, where it only closes the gate.
// - Settings change only on an enter action, apart from a non-trigger command leaving burst.
`timescale 1ns/10ps
`default_nettype none
module measurement_trigger_sequencer
	import remote_trigger_command_seq_pkg::*;
#(
	parameter int unsigned debounce_cycles = debounce_cycles_dflt,
	parameter int unsigned gate_cycles = gate_latency_cycles
) (
	input wire logic clock,
	input wire logic srst,
	input wire settings_t pending_settings,
	input wire logic enter_action,
	input wire logic other_command,
	input wire meas_func_t meas_func,
	input wire logic [3:0] range_index,
	input wire logic [2:0] supported_digits,
	input wire logic trigger_key,
	input wire logic external_trigger_in,
	input wire logic timer_trigger,
	input wire logic remote_trigger_command,
	input wire logic measure_complete,
	input wire logic threshold_hit,
	input wire logic bound_violation,
	input wire logic bound_alarm_on,
	input wire logic [31:0] measured_value,
	input wire logic [31:0] integration_ticks,
	output settings_t active_settings,
	output logic [2:0] displayed_digits,
	output start_event_t start_event,
	output logic measure_request,
	output logic gate_open,
	output logic trigger_indicator,
	output logic integral_indicator,
	output logic [63:0] integral_value,
	output logic [31:0] gate_ticks,
	output logic config_error,
	output logic measure_done_pulse
);

	typedef enum logic [2:0] {
		st_idle,
		st_run,
		st_gate,
		st_capture_wait,
		st_overrun
	} seq_state_t;

	localparam int unsigned done_cnt_w = $clog2(done_pulse_cycles + 1);
	localparam int unsigned deb_w = $clog2(debounce_cycles + 1);

	// Burst needs dc volts, dc current or a fixed ohm range inside the allowed span.
	function automatic logic burst_legal(input meas_func_t f, input logic [3:0] rng,
			input logic autor);
		burst_legal = !autor && (f == func_vdc || f == func_idc ||
			(f == func_ohm && rng >= kohm_range_lo && rng <= kohm_range_hi));
	endfunction : burst_legal

	// Clamps a count to 1 up to the memory limit; a count of zero is stored as 1.
	function automatic logic [12:0] clamp_count(input logic [12:0] c, input logic exp_mem);
		logic [12:0] lim;
		lim = exp_mem ? 13'(count_max_exp) : 13'(count_max_std);
		if (c == 13'h0000)
			clamp_count = 13'h0001;
		else if (c > lim)
			clamp_count = lim;
		else
			clamp_count = c;
	endfunction : clamp_count

	settings_t set_r;
	settings_t set_nxt;
	seq_state_t state_r;
	logic [12:0] remaining_r;
	logic ext_meta_r;
	logic ext_sync_r;
	logic ext_stable_r;
	logic ext_prev_r;
	logic [deb_w-1:0] deb_cnt_r;
	logic [done_cnt_w-1:0] done_cnt_r;
	logic ext_edge;
	logic remote_trigger_command_any;
	logic done_event;
	logic bad_burst;
	logic bad_gate;
	logic bad;

	// Settings are validated and forced into shape when enter is seen.
	always_comb begin
		set_nxt = pending_settings;
		if (set_nxt.digits < digits_min)
			set_nxt.digits = digits_min;
		if (set_nxt.digits > digits_max)
			set_nxt.digits = digits_max;
		if (set_nxt.integration_time_setting < 17'(integration_time_setting_min))
			set_nxt.integration_time_setting = 17'(integration_time_setting_min);
		if (set_nxt.integration_time_setting > 17'(integration_time_setting_max))
			set_nxt.integration_time_setting = 17'(integration_time_setting_max);
		set_nxt.count = clamp_count(set_nxt.count, set_nxt.expanded);
		set_nxt.overrun = clamp_count(set_nxt.overrun, set_nxt.expanded);
		if (set_nxt.mode == acq_capture)
			set_nxt.scan = 1'b0;
		if (set_nxt.mode == acq_burst) begin
			set_nxt.digits = burst_digits;
			set_nxt.filter = 1'b0;
			set_nxt.quotient = 1'b0;
			set_nxt.scan = 1'b0;
			set_nxt.track = 1'b0;
			set_nxt.normal_output = 1'b1;
		end
	end

	// Enter takes the whole checked set; a non-trigger command only leaves burst.
	always_ff @(posedge clock) begin
		if (srst) begin
			set_r <= '0;
			set_r.digits <= digits_max;
			set_r.integration_time_setting <= 17'(integration_time_setting_min);
			set_r.count <= 13'h0001;
			set_r.overrun <= 13'h0001;
			set_r.autorange <= 1'b1;
			set_r.normal_output <= 1'b1;
		end else if (enter_action) begin
			set_r <= set_nxt;
		end else if (other_command && set_r.mode == acq_burst) begin
			set_r.mode <= acq_sample;
		end
	end

	assign active_settings = set_r;

	// With integration time active, show the smaller of stored and supported.
	always_comb begin
		if (set_r.integration_time_setting_on && set_r.digits > supported_digits)
			displayed_digits = supported_digits;
		else
			displayed_digits = set_r.digits;
	end

	// The synchroniser keeps sampling through reset, so the stages behind it can be loaded
	// with the settled pin level and no false edge follows reset.
	always_ff @(posedge clock) begin
		ext_meta_r <= external_trigger_in;
		ext_sync_r <= ext_meta_r;
	end

	// With debounce on, a new level is taken only after it has held for debounce_cycles
	// clocks; with debounce off the synchronised level passes straight through.
	always_ff @(posedge clock) begin
		if (srst) begin
			ext_stable_r <= ext_sync_r;
			deb_cnt_r <= '0;
		end else if (!set_r.ext_edge_neg_debounce[0]) begin
			ext_stable_r <= ext_sync_r;
			deb_cnt_r <= '0;
		end else if (ext_sync_r == ext_stable_r) begin
			deb_cnt_r <= '0;
		end else if (deb_cnt_r == deb_w'(debounce_cycles - 1)) begin
			ext_stable_r <= ext_sync_r;
			deb_cnt_r <= '0;
		end else begin
			deb_cnt_r <= deb_cnt_r + 1'b1;
		end
	end

	// Reset loads the previous level from the same source as the stable level.
	always_ff @(posedge clock) begin
		if (srst)
			ext_prev_r <= ext_sync_r;
		else
			ext_prev_r <= ext_stable_r;
	end

	// Bit 1 of the external trigger setting selects the falling edge.
	assign ext_edge = set_r.ext_edge_neg_debounce[1] ? (ext_prev_r && !ext_stable_r)
		: (!ext_prev_r && ext_stable_r);

	// Key, external edge, timer and remote command are merged into one trigger.
	assign remote_trigger_command_any = trigger_key || ext_edge || timer_trigger
		|| remote_trigger_command;
	assign bad_burst = set_r.mode == acq_burst
		&& !burst_legal(meas_func, range_index, set_r.autorange);
	assign bad_gate = set_r.mode == acq_gated && (set_r.comp_ohm || set_r.quotient
		|| set_r.scan || set_r.autorange);
	// A refused configuration still reports through start_event.error and config_error.
	assign bad = bad_burst || bad_gate;

	// One start event per accepted trigger, with source priority key first.
	always_ff @(posedge clock) begin
		if (srst) begin
			start_event <= '0;
		end else begin
			start_event.start <= remote_trigger_command_any && !bad && state_r != st_gate;
			start_event.mode <= set_r.mode;
			start_event.error <= remote_trigger_command_any && bad;
			if (trigger_key)
				start_event.src <= src_key;
			else if (ext_edge)
				start_event.src <= src_ext;
			else if (timer_trigger)
				start_event.src <= src_timer;
			else if (remote_trigger_command)
				start_event.src <= src_remote;
			else
				start_event.src <= src_none;
		end
	end

	// The error flag describes the most recent trigger and clears on the next legal one.
	always_ff @(posedge clock) begin
		if (srst)
			config_error <= 1'b0;
		else if (remote_trigger_command_any)
			config_error <= bad;
	end

	// Acquisition sequencer; a new trigger restarts from any state except st_gate, where it closes the gate.
	always_ff @(posedge clock) begin
		if (srst) begin
			state_r <= st_idle;
			remaining_r <= '0;
		end else if (remote_trigger_command_any && !bad && state_r == st_gate) begin
			// A trigger while the gate is open closes it and starts nothing new.
			state_r <= st_idle;
		end else if (remote_trigger_command_any && !bad) begin
			remaining_r <= set_r.count;
			case (set_r.mode)
				acq_gated: state_r <= st_gate;
				acq_capture: state_r <= st_capture_wait;
				default: state_r <= st_run;
			endcase
		end else begin
			case (state_r)
				st_run: begin
					if (measure_complete) begin
						if (remaining_r <= 13'h0001)
							state_r <= st_idle;
						remaining_r <= remaining_r - 1'b1;
					end
				end
				st_capture_wait: begin
					if (measure_complete && threshold_hit) begin
						state_r <= st_overrun;
						remaining_r <= set_r.overrun;
					end
				end
				st_overrun: begin
					if (measure_complete) begin
						if (remaining_r <= 13'h0001)
							state_r <= st_idle;
						remaining_r <= remaining_r - 1'b1;
					end
				end
				// An open gate waits for the closing trigger, handled above.
				st_gate: state_r <= st_gate;
				default: state_r <= st_idle;
			endcase
		end
	end

	assign gate_open = state_r == st_gate;
	assign trigger_indicator = state_r != st_idle;
	// In track the engine is asked to measure whenever no acquisition is running.
	assign measure_request = (state_r == st_run || state_r == st_capture_wait
		|| state_r == st_overrun || (state_r == st_idle && set_r.track));

	// Gate timer and integral product.
	always_ff @(posedge clock) begin
		if (srst)
			gate_ticks <= '0;
		else if (remote_trigger_command_any && !bad && state_r != st_gate && set_r.mode == acq_gated)
			gate_ticks <= '0;
		else if (state_r == st_gate)
			gate_ticks <= gate_ticks + 1'b1;
	end

	// The indicator lights with the first product and goes out when the option is off.
	always_ff @(posedge clock) begin
		if (srst) begin
			integral_value <= '0;
			integral_indicator <= 1'b0;
		end else if (set_r.integral_on && measure_complete) begin
			integral_indicator <= 1'b1;
			if (set_r.mode == acq_gated)
				integral_value <= measured_value * gate_ticks;
			else
				integral_value <= measured_value * integration_ticks;
		end else if (!set_r.integral_on) begin
			integral_indicator <= 1'b0;
		end
	end

	// Done pulse: first threshold result in capture, none in overrun.
	always_comb begin
		case (state_r)
			st_capture_wait: done_event = measure_complete && threshold_hit;
			st_overrun: done_event = 1'b0;
			default: done_event = measure_complete;
		endcase
		if (bound_alarm_on && bound_violation)
			done_event = 1'b1;
	end

	// A new event while the output is low restarts the count, so close events merge into
	// one longer low pulse instead of being lost.
	always_ff @(posedge clock) begin
		if (srst)
			done_cnt_r <= '0;
		else if (done_event)
			done_cnt_r <= done_cnt_w'(done_pulse_cycles);
		else if (done_cnt_r != '0)
			done_cnt_r <= done_cnt_r - 1'b1;
	end

	assign measure_done_pulse = done_cnt_r == '0;

endmodule : measurement_trigger_sequencer
`default_nettype wire

// File: verification/remote_trigger_command_seq_assertions.sv
// Concurrent checks on the trigger sequencer ports.
`timescale 1ns/10ps
`default_nettype none
module remote_trigger_command_seq_assertions
	import remote_trigger_command_seq_pkg::*;
(
	input wire logic clock,
	input wire logic srst,
	input wire logic enter_action,
	input wire logic other_command,
	input wire logic trigger_key,
	input wire logic [2:0] supported_digits,
	input wire settings_t active_settings,
	input wire logic [2:0] displayed_digits,
	input wire start_event_t start_event,
	input wire logic gate_open,
	input wire logic trigger_indicator,
	input wire logic measure_done_pulse
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);
	sequence done_low;
		!measure_done_pulse [*8];
	endsequence
	a_start_one_cycle: assert property (start_event.start |=> !start_event.start)
		else $error("start event longer than one cycle");
	a_key_starts: assert property (trigger_key && !gate_open |=>
		(start_event.start && start_event.src == src_key) || start_event.error)
		else $error("key trigger gave no start");
	a_error_no_start: assert property (start_event.error |-> !start_event.start)
		else $error("refused trigger also started");
	a_indicator_lit: assert property (start_event.start |-> ##[0:1] trigger_indicator)
		else $error("indicator not lit after start");
	a_done_pulse_width: assert property ($fell(measure_done_pulse) |-> done_low)
		else $error("done pulse too short");
	a_digits_shown: assert property (displayed_digits ==
		((active_settings.integration_time_setting_on && supported_digits < active_settings.digits) ?
		supported_digits : active_settings.digits))
		else $error("displayed digits wrong");
	a_enter_only: assert property (!enter_action && !other_command |=>
		$stable(active_settings))
		else $error("settings changed without enter");
	a_burst_forced: assert property (active_settings.mode == acq_burst |->
		active_settings.digits == burst_digits && !active_settings.filter &&
		!active_settings.quotient && !active_settings.scan && !active_settings.track &&
		active_settings.normal_output)
		else $error("burst settings not forced");
	a_capture_no_scan: assert property (active_settings.mode == acq_capture |->
		!active_settings.scan)
		else $error("scan on in capture");
	a_burst_exit: assert property (other_command && !enter_action &&
		active_settings.mode == acq_burst |=> active_settings.mode == acq_sample)
		else $error("burst kept after other command");
endmodule : remote_trigger_command_seq_assertions
bind measurement_trigger_sequencer remote_trigger_command_seq_assertions chk_i (.clock(clock), .srst(srst),
	.enter_action(enter_action), .other_command(other_command), .trigger_key(trigger_key),
	.supported_digits(supported_digits), .active_settings(active_settings),
	.displayed_digits(displayed_digits), .start_event(start_event), .gate_open(gate_open),
	.trigger_indicator(trigger_indicator), .measure_done_pulse(measure_done_pulse));
`default_nettype wire

// File: verification/remote_trigger_command_partner.sv
// Model of the external trigger circuit and the remote controller.
`timescale 1ns/10ps
`default_nettype none
module remote_trigger_command_partner (
	input wire logic clock,
	input wire logic fire_ext,
	input wire logic fire_rem,
	input wire logic neg_edge,
	output logic external_trigger_in,
	output logic remote_trigger_command = 1'h0
);
	logic [3:0] hold_r = 4'h0;
	// The pin moves on the falling clock edge, out of phase with the sampling edge.
	assign external_trigger_in = neg_edge ^ (hold_r != 4'h0);
	always @(negedge clock) begin
		hold_r <= fire_ext ? 4'hF : hold_r - {3'h0, hold_r != 4'h0};
	end
	always @(posedge clock) begin
		remote_trigger_command <= fire_rem;
	end
endmodule : remote_trigger_command_partner
`default_nettype wire

// File: verification/testbench.sv
// Self-checking testbench for the measurement trigger sequencer.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import remote_trigger_command_seq_pkg::*;
	logic clock = 1'h0;
	logic srst = 1'h1;
	logic [7:0] strb = 8'h00;
	localparam logic [7:0] ent = 8'h01;
	localparam logic [7:0] oth = 8'h02;
	localparam logic [7:0] key = 8'h04;
	localparam logic [7:0] tmr = 8'h08;
	localparam logic [7:0] mc = 8'h10;
	localparam logic [7:0] fx = 8'h20;
	localparam logic [7:0] fr = 8'h40;
	localparam logic [7:0] viol = 8'h80;
	logic thr = 1'h0;
	logic alarm = 1'h0;
	logic neg = 1'h0;
	logic ext;
	logic rem;
	meas_func_t func = func_vdc;
	logic [3:0] rng = 4'h3;
	logic [2:0] sup = 3'h7;
	settings_t ps;
	settings_t nx;
	settings_t act;
	start_event_t ev;
	logic [2:0] shown;
	logic gate;
	logic ind;
	logic done;
	int err_count = 0;
	int comparisons = 0;
	int cycles = 0;
	measurement_trigger_sequencer #(.debounce_cycles(4)) uut (
		.clock(clock), .srst(srst), .pending_settings(ps), .enter_action(strb[0]),
		.other_command(strb[1]), .meas_func(func), .range_index(rng), .supported_digits(sup),
		.trigger_key(strb[2]), .external_trigger_in(ext), .timer_trigger(strb[3]),
		.remote_trigger_command(rem), .measure_complete(strb[4]), .threshold_hit(thr),
		.bound_violation(strb[7]), .bound_alarm_on(alarm), .measured_value(32'h0),
		.integration_ticks(32'h0), .active_settings(act), .displayed_digits(shown),
		.start_event(ev), .measure_request(), .gate_open(gate), .trigger_indicator(ind),
		.integral_indicator(), .integral_value(), .gate_ticks(), .config_error(),
		.measure_done_pulse(done));
	remote_trigger_command_partner far (.clock(clock), .fire_ext(strb[5]), .fire_rem(strb[6]), .neg_edge(neg),
		.external_trigger_in(ext), .remote_trigger_command(rem));
	always #5 clock = ~clock;
	task chk(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task conclude;
		if (err_count == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : conclude
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			conclude;
		end
	end
	task step;
		@(posedge clock);
		#1;
	endtask : step
	task pulse(input logic [7:0] s);
		@(posedge clock);
		strb <= s;
		@(posedge clock);
		strb <= 8'h00;
	endtask : pulse
	task automatic cfg(input settings_t s);
		@(posedge clock);
		ps <= s;
		pulse(ent);
		step;
	endtask : cfg
	task wstart(input remote_trigger_command_src_t s);
		#1;
		for (int i = 0; i < 16 && ev.start !== 1'h1; i++) step;
		chk(ev.start, 1'h1);
		chk(ev.src, s);
	endtask : wstart
	task wdone;
		for (int i = 0; i < 8 && done !== 1'h0; i++) step;
		chk(done, 1'h0);
		repeat (390) @(posedge clock);
		#1;
		chk(done, 1'h0);
		repeat (20) @(posedge clock);
		#1;
		chk(done, 1'h1);
	endtask : wdone
	initial begin
		nx = '0;
		nx.digits = 3'h7;
		nx.filter = 1'h1;
		nx.integration_time_setting = 17'h1;
		nx.count = 13'h3;
		nx.overrun = 13'h1;
		nx.normal_output = 1'h1;
		ps = nx;
		repeat (5) @(posedge clock);
		srst <= 1'h0;
		step;
		chk(act.digits, 3'h7);
		chk(done, 1'h1);
		chk(ind, 1'h0);
		cfg(nx);
		pulse(key);
		wstart(src_key);
		chk(ind, 1'h1);
		repeat (2) pulse(mc);
		step;
		chk(ind, 1'h1);
		pulse(mc);
		repeat (4) step;
		chk(ind, 1'h0);
		wdone;
		pulse(key);
		wstart(src_key);
		pulse(mc);
		pulse(tmr);
		wstart(src_timer);
		pulse(fr);
		wstart(src_remote);
		pulse(fx);
		wstart(src_ext);
		repeat (20) step;
		nx.ext_edge_neg_debounce = 2'h3;
		cfg(nx);
		@(posedge clock);
		neg <= 1'h1;
		repeat (20) step;
		pulse(fx);
		wstart(src_ext);
		nx.mode = acq_burst;
		@(posedge clock);
		func <= func_other;
		cfg(nx);
		pulse(key);
		#1;
		chk(ev.error, 1'h1);
		chk(ev.start, 1'h0);
		@(posedge clock);
		func <= func_vdc;
		cfg(nx);
		chk(act.digits, burst_digits);
		chk(act.filter, 1'h0);
		pulse(key);
		wstart(src_key);
		chk(ev.mode, acq_burst);
		pulse(oth);
		#1;
		chk(act.mode, acq_sample);
		nx.mode = acq_gated;
		nx.scan = 1'h1;
		cfg(nx);
		pulse(key);
		#1;
		chk(ev.error, 1'h1);
		nx.scan = 1'h0;
		cfg(nx);
		pulse(key);
		wstart(src_key);
		repeat (3) step;
		chk(gate, 1'h1);
		pulse(key);
		repeat (3) step;
		chk(gate, 1'h0);
		nx.mode = acq_capture;
		nx.scan = 1'h1;
		nx.overrun = 13'h2;
		cfg(nx);
		chk(act.scan, 1'h0);
		pulse(key);
		wstart(src_key);
		for (int i = 0; i < 500 && done !== 1'h1; i++) step;
		repeat (2) pulse(mc);
		step;
		chk(ind, 1'h1);
		chk(done, 1'h1);
		@(posedge clock);
		thr <= 1'h1;
		pulse(mc);
		thr <= 1'h0;
		step;
		chk(done, 1'h0);
		chk(ind, 1'h1);
		for (int i = 0; i < 500 && done !== 1'h1; i++) step;
		chk(done, 1'h1);
		pulse(mc);
		step;
		chk(done, 1'h1);
		chk(ind, 1'h1);
		pulse(mc);
		step;
		chk(ind, 1'h0);
		nx.integration_time_setting_on = 1'h1;
		@(posedge clock);
		sup <= 3'h5;
		cfg(nx);
		chk(shown, 3'h5);
		chk(act.digits, 3'h7);
		nx.digits = 3'h4;
		cfg(nx);
		chk(shown, 3'h4);
		nx.digits = 3'h6;
		@(posedge clock);
		ps <= nx;
		repeat (3) step;
		chk(act.digits, 3'h4);
		pulse(viol);
		step;
		chk(done, 1'h1);
		@(posedge clock);
		alarm <= 1'h1;
		pulse(viol);
		step;
		chk(done, 1'h0);
		conclude;
	end
endmodule : testbench
`default_nettype wire
